// [design/axc_cfg.svh]
`ifndef AXC_CFG_SVH
`define AXC_CFG_SVH

// ----------------------------------------------------------------------
// target address, pointer map, reset values
// ----------------------------------------------------------------------
`define AXC_ADDR_FIXED    6'h0C
`define AXC_PTR_RESULT0   8'h00
`define AXC_PTR_RESULT5   8'h05
`define AXC_PTR_CTRL2     8'h0E
`define AXC_CTRL2_RST     8'h00
`define AXC_HOLD_BIT      0
`define AXC_ZERO_G        12'h800
`define AXC_PIN_RST       3'h3

// ----------------------------------------------------------------------
// bit counts and timing
// ----------------------------------------------------------------------
`define AXC_BYTE_BITS     4'h8
`define AXC_LAST_TX_BIT   4'h7
`define AXC_CONV_TIME_US  200
`define AXC_CLK_MHZ       100
`define AXC_CONV_CYCLES   (`AXC_CONV_TIME_US * `AXC_CLK_MHZ)

`endif

// [design/axc_pkg.sv]
package axc_pkg;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0000,
    ST_ADDR   = 4'b0001,
    ST_WR     = 4'b0010,
    ST_ACK    = 4'b0011,
    ST_HOLD   = 4'b0100,
    ST_RD     = 4'b0101,
    ST_RACK   = 4'b0110,
    ST_IGNORE = 4'b0111
  } axc_state_t;

endpackage : axc_pkg

// [design/axc_conv_wait.sv]
`timescale 1ns/10ps
`include "axc_cfg.svh"

module axc_conv_wait
  import axc_pkg::*;
#(
  parameter int CYCLES = `AXC_CONV_CYCLES
)
(
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic start,
  input  wire logic done,
  output logic      busy
);

  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic          busy_ff;
  logic          nxt_busy;

  // ----------------------------------------------------------------------
  // conversion window: ends on done or when the longest time runs out
  // ----------------------------------------------------------------------
  always_comb
  begin
    nxt_cnt  = cnt_ff;
    nxt_busy = busy_ff;
    if (start)
    begin
      nxt_busy = 1'b1;
      nxt_cnt  = CW'(CYCLES);
    end
    else if (busy_ff)
    begin
      nxt_cnt = cnt_ff - CW'(1);
      if (done || cnt_ff == CW'(1))
        nxt_busy = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cnt_ff  <= '0;
      busy_ff <= 1'b0;
    end
    else
    begin
      cnt_ff  <= nxt_cnt;
      busy_ff <= nxt_busy;
    end
  end

  assign busy = busy_ff;

  conv_bound_a: assert property (@(posedge clk) disable iff (sys_rst)
    busy_ff && cnt_ff == CW'(1) |=> !busy_ff) // see [R18]
    else $error("conversion wait overran its limit");

endmodule : axc_conv_wait

// [design/axc_i2c_target.sv]
// Notes on behaviour
// [R1] controller opens with start: data falls, clock high
// [R2] first byte: seven address bits, then direction
// [R3] match address 001100 plus strap bit
// [R4] receiver pulls data low through ack pulse
// [R5] stop: data rises with clock high, bus free
// [R6] both lines high means idle bus
// [R7] bytes eight bits, msb first, unlimited count
// [R8] write: address, pointer, data, each acknowledged
// [R9] controller sends pointer with msb clear
// [R10] pointer advances after each written data byte
// [R11] read: pointer write, repeated start, read address
// [R12] controller nacks last byte then stops
// [R13] pointer advances after each acknowledged read byte
// [R14] clock held low until conversion completes
// [R15] hold clock only when hold bit set
// [R16] controller programs control registers after power-up
// [R17] two g range: 2048 counts at zero g
// [R18] pointer zero starts conversion, six result bytes
// [R19] result: 12 bits left-justified, four zero pads
// [R20] wrong address: no ack, ignore until start
`timescale 1ns/10ps
`include "axc_cfg.svh"

module axc_i2c_target
  import axc_pkg::*;
#(
  parameter int CONV_CYCLES = `AXC_CONV_CYCLES
)
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  input  wire logic        addr_strap,
  output logic             scl_out,
  output logic             scl_oe,
  output logic             sda_out,
  output logic             sda_oe,
  output logic [7:0]       register_pointer,
  output logic             reg_wr_stb,
  output logic [7:0]       reg_wr_data,
  input  wire logic [7:0]  reg_rd_data,
  output logic [7:0]       control_register_two,
  output logic             conv_start,
  input  wire logic        conv_done,
  input  wire logic [11:0] x_sample,
  input  wire logic [11:0] y_sample,
  input  wire logic [11:0] z_sample,
  output logic             bus_busy
);

  // ----------------------------------------------------------------------
  // pin synchronisers: scl, sda, strap
  // ----------------------------------------------------------------------
  logic [2:0] pin_in;
  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  logic [1:0] dly_ff;
  logic       scl_s;
  logic       sda_s;
  logic       strap_s;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_cond;
  logic       stop_cond;

  assign pin_in = {addr_strap, sda_in, scl_in};

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sync1_ff <= `AXC_PIN_RST;
      sync2_ff <= `AXC_PIN_RST;
      dly_ff   <= 2'h3;
    end
    else
    begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
      dly_ff   <= sync2_ff[1:0];
    end
  end

  assign scl_s      = sync2_ff[0];
  assign sda_s      = sync2_ff[1];
  assign strap_s    = sync2_ff[2];
  assign scl_rise   = scl_s & ~dly_ff[0];
  assign scl_fall   = ~scl_s & dly_ff[0];
  // clock high on both samples so a data edge beside a clock edge is
  // never mistaken for a condition
  assign start_cond = scl_s & dly_ff[0] & ~sda_s & dly_ff[1]; // see [R1]
  assign stop_cond  = scl_s & dly_ff[0] & sda_s & ~dly_ff[1]; // see [R5]

  // ----------------------------------------------------------------------
  // conversion results
  // ----------------------------------------------------------------------
  logic [11:0] res_ff  [3];
  logic [11:0] nxt_res [3];
  logic        conv_busy;

  always_comb
  begin
    nxt_res = res_ff;
    if (conv_done)
    begin
      nxt_res[0] = x_sample;
      nxt_res[1] = y_sample;
      nxt_res[2] = z_sample;
    end
  end

  always_ff @(posedge clk)
  begin
    for (int i = 0; i < 3; i++)
    begin
      if (sys_rst)
        res_ff[i] <= `AXC_ZERO_G; // see [R17]
      else
        res_ff[i] <= nxt_res[i];
    end
  end

  axc_conv_wait #(
    .CYCLES (CONV_CYCLES)
  ) u_conv (
    .clk     (clk),
    .sys_rst (sys_rst),
    .start   (conv_start),
    .done    (conv_done),
    .busy    (conv_busy)
  );

  // ----------------------------------------------------------------------
  // protocol state
  // ----------------------------------------------------------------------
  axc_state_t st_ff;
  axc_state_t nxt_st;
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic [7:0] sh_ff;
  logic [7:0] nxt_sh;
  logic [7:0] tx_ff;
  logic [7:0] nxt_tx;
  logic [7:0] ptr_ff;
  logic [7:0] nxt_ptr;
  logic [7:0] ctrl2_ff;
  logic [7:0] nxt_ctrl2;
  logic [7:0] wr_data_ff;
  logic [7:0] nxt_wr_data;
  logic       sda_oe_ff;
  logic       nxt_sda_oe;
  logic       scl_oe_ff;
  logic       nxt_scl_oe;
  logic       rw_ff;
  logic       nxt_rw;
  logic       first_ff;
  logic       nxt_first;
  logic       hold_ff;
  logic       nxt_hold;
  logic       acked_ff;
  logic       nxt_acked;
  logic       wr_stb_ff;
  logic       nxt_wr_stb;
  logic       conv_ff;
  logic       nxt_conv;
  logic       busy_ff;
  logic       nxt_busy;
  logic       addr_hit;

  assign addr_hit = (sh_ff[7:1] == {`AXC_ADDR_FIXED, strap_s}); // see [R3]

  // byte to send at the current pointer
  logic [7:0]  rd_byte;
  logic [11:0] res_sel;

  always_comb
  begin
    res_sel = res_ff[ptr_ff[2:1] == 2'h0 ? 0 : (ptr_ff[2:1] == 2'h1 ? 1 : 2)];
    if (ptr_ff <= `AXC_PTR_RESULT5)
      rd_byte = ptr_ff[0] ? {res_sel[3:0], 4'h0} : res_sel[11:4]; // see [R19]
    else if (ptr_ff == `AXC_PTR_CTRL2)
      rd_byte = ctrl2_ff;
    else
      rd_byte = reg_rd_data;
  end

  always_comb
  begin
    nxt_st      = st_ff;
    nxt_cnt     = cnt_ff;
    nxt_sh      = sh_ff;
    nxt_tx      = tx_ff;
    nxt_ptr     = ptr_ff;
    nxt_ctrl2   = ctrl2_ff;
    nxt_wr_data = wr_data_ff;
    nxt_sda_oe  = sda_oe_ff;
    nxt_scl_oe  = scl_oe_ff;
    nxt_rw      = rw_ff;
    nxt_first   = first_ff;
    nxt_hold    = hold_ff;
    nxt_acked   = acked_ff;
    nxt_wr_stb  = 1'b0;
    nxt_conv    = 1'b0;
    nxt_busy    = busy_ff;
    if (start_cond)
    begin
      // a repeated start also lands here
      nxt_busy   = 1'b1; // see [R1]
      nxt_st     = ST_ADDR;
      nxt_cnt    = 4'h0;
      nxt_sda_oe = 1'b0;
      nxt_scl_oe = 1'b0;
      nxt_hold   = 1'b0;
    end
    else if (stop_cond)
    begin
      nxt_busy   = 1'b0; // see [R5] [R6]
      nxt_st     = ST_IDLE;
      nxt_sda_oe = 1'b0;
      nxt_scl_oe = 1'b0;
      nxt_hold   = 1'b0;
    end
    else
    begin
      unique case (st_ff)
        ST_IDLE, ST_IGNORE:
          nxt_sda_oe = 1'b0; // see [R20]
        ST_ADDR, ST_WR:
        begin
          if (scl_rise && cnt_ff != `AXC_BYTE_BITS)
          begin
            nxt_sh  = {sh_ff[6:0], sda_s}; // see [R7]
            nxt_cnt = cnt_ff + 4'h1;
          end
          else if (scl_fall && cnt_ff == `AXC_BYTE_BITS)
          begin
            nxt_cnt = 4'h0;
            if (st_ff == ST_ADDR)
            begin
              if (addr_hit)
              begin
                nxt_sda_oe = 1'b1; // see [R4]
                nxt_rw     = sh_ff[0]; // see [R2]
                nxt_first  = 1'b1;
                nxt_st     = ST_ACK;
              end
              else
                nxt_st = ST_IGNORE; // see [R20]
            end
            else
            begin
              nxt_sda_oe = 1'b1; // see [R4] [R8]
              nxt_st     = ST_ACK;
              if (first_ff)
              begin
                // pointer msb is trusted to be clear
                nxt_ptr   = sh_ff; // see [R9]
                nxt_first = 1'b0;
                if (sh_ff == `AXC_PTR_RESULT0)
                begin
                  nxt_conv = 1'b1; // see [R18]
                  nxt_hold = ctrl2_ff[`AXC_HOLD_BIT]; // see [R15]
                end
              end
              else
              begin
                nxt_wr_stb  = 1'b1; // see [R8]
                nxt_wr_data = sh_ff;
                if (ptr_ff == `AXC_PTR_CTRL2)
                  nxt_ctrl2 = sh_ff;
                nxt_ptr = ptr_ff + 8'h01; // see [R10]
              end
            end
          end
        end
        ST_ACK:
          if (scl_fall)
          begin
            nxt_sda_oe = 1'b0;
            if (rw_ff)
            begin
              nxt_tx     = rd_byte; // see [R11]
              nxt_sda_oe = ~rd_byte[7];
              nxt_cnt    = 4'h0;
              nxt_st     = ST_RD;
            end
            else if (hold_ff)
            begin
              nxt_scl_oe = 1'b1; // see [R14]
              nxt_hold   = 1'b0;
              nxt_st     = ST_HOLD;
            end
            else
              nxt_st = ST_WR;
          end
        ST_HOLD:
          if (!conv_busy)
          begin
            nxt_scl_oe = 1'b0; // see [R14]
            nxt_st     = ST_WR;
          end
        ST_RD:
          if (scl_fall)
          begin
            if (cnt_ff == `AXC_LAST_TX_BIT)
            begin
              nxt_sda_oe = 1'b0; // see [R4]
              nxt_acked  = 1'b0;
              nxt_st     = ST_RACK;
            end
            else
            begin
              nxt_tx     = {tx_ff[6:0], 1'b0}; // see [R7]
              nxt_sda_oe = ~tx_ff[6];
              nxt_cnt    = cnt_ff + 4'h1;
            end
          end
        ST_RACK:
        begin
          if (scl_rise)
          begin
            nxt_acked = ~sda_s;
            if (!sda_s)
              nxt_ptr = ptr_ff + 8'h01; // see [R13]
          end
          else if (scl_fall)
          begin
            if (acked_ff)
            begin
              nxt_tx     = rd_byte; // see [R18]
              nxt_sda_oe = ~rd_byte[7];
              nxt_cnt    = 4'h0;
              nxt_st     = ST_RD;
            end
            else
              nxt_st = ST_IGNORE; // see [R12]
          end
        end
        default:
          nxt_st = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_ff      <= ST_IDLE;
      cnt_ff     <= 4'h0;
      sh_ff      <= 8'h00;
      tx_ff      <= 8'h00;
      ptr_ff     <= 8'h00;
      ctrl2_ff   <= `AXC_CTRL2_RST;
      wr_data_ff <= 8'h00;
      sda_oe_ff  <= 1'b0;
      scl_oe_ff  <= 1'b0;
      rw_ff      <= 1'b0;
      first_ff   <= 1'b0;
      hold_ff    <= 1'b0;
      acked_ff   <= 1'b0;
      wr_stb_ff  <= 1'b0;
      conv_ff    <= 1'b0;
      busy_ff    <= 1'b0;
    end
    else
    begin
      st_ff      <= nxt_st;
      cnt_ff     <= nxt_cnt;
      sh_ff      <= nxt_sh;
      tx_ff      <= nxt_tx;
      ptr_ff     <= nxt_ptr;
      ctrl2_ff   <= nxt_ctrl2;
      wr_data_ff <= nxt_wr_data;
      sda_oe_ff  <= nxt_sda_oe;
      scl_oe_ff  <= nxt_scl_oe;
      rw_ff      <= nxt_rw;
      first_ff   <= nxt_first;
      hold_ff    <= nxt_hold;
      acked_ff   <= nxt_acked;
      wr_stb_ff  <= nxt_wr_stb;
      conv_ff    <= nxt_conv;
      busy_ff    <= nxt_busy;
    end
  end

  // open drain: only ever drives low, so the data flops hold zero
  logic zero_ff;

  always_ff @(posedge clk)
  begin
    zero_ff <= 1'b0;
  end

  assign scl_out              = zero_ff;
  assign sda_out              = zero_ff;
  assign scl_oe               = scl_oe_ff;
  assign sda_oe               = sda_oe_ff;
  assign register_pointer     = ptr_ff;
  assign reg_wr_stb           = wr_stb_ff;
  assign reg_wr_data          = wr_data_ff;
  assign control_register_two = ctrl2_ff;
  assign conv_start           = conv_ff;
  assign bus_busy             = busy_ff;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  start_detect_a: assert property (start_cond |=> st_ff == ST_ADDR && busy_ff) // see [R1]
    else $error("start not taken");
  stop_idle_a: assert property (stop_cond |=> st_ff == ST_IDLE && !busy_ff) // see [R5]
    else $error("stop not taken");
  addr_nack_a: assert property (st_ff == ST_ADDR && !start_cond && !stop_cond // see [R20]
    && scl_fall && cnt_ff == `AXC_BYTE_BITS && !addr_hit
    |=> !sda_oe_ff && st_ff == ST_IGNORE)
    else $error("acked a foreign address");
  addr_ack_a: assert property (st_ff == ST_ADDR && !start_cond && !stop_cond // see [R3]
    && scl_fall && cnt_ff == `AXC_BYTE_BITS && addr_hit |=> sda_oe_ff)
    else $error("own address not acked");
  ack_stable_a: assert property (st_ff == ST_ACK && scl_rise // see [R4]
    |-> sda_oe_ff throughout (scl_s [*2]))
    else $error("ack released in clock high");
  wr_ptr_inc_a: assert property (wr_stb_ff |-> ptr_ff == $past(ptr_ff) + 8'h01) // see [R10]
    else $error("pointer not advanced on write");
  rd_ptr_inc_a: assert property (st_ff == ST_RACK && scl_rise && !sda_s // see [R13]
    && !start_cond && !stop_cond |=> ptr_ff == $past(ptr_ff) + 8'h01)
    else $error("pointer not advanced on read ack");
  no_stretch_a: assert property ($rose(scl_oe_ff) // see [R15]
    |-> ctrl2_ff[`AXC_HOLD_BIT] && $past(conv_busy, 2))
    else $error("clock held without hold bit");
  hold_release_a: assert property (st_ff == ST_HOLD && !conv_busy // see [R14]
    && !start_cond && !stop_cond |=> !scl_oe_ff ##1 !scl_oe_ff)
    else $error("clock not released");
  msb_first_a: assert property (st_ff == ST_RD && scl_fall && !start_cond // see [R7]
    && !stop_cond && cnt_ff != `AXC_LAST_TX_BIT |=> sda_oe_ff == !$past(tx_ff[6]))
    else $error("bit order broken");

endmodule : axc_i2c_target

// [verif/axc_ctl_model.sv]
`timescale 1ns/10ps

module axc_ctl_model
(
  input  wire logic clk,
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_pull,
  output logic      sda_pull,
  output logic      bus_err
);
  // ----------------------------------------------------------
  // bus controller: bit cell of 5 low and 3 high clocks, 80 ns
  // ----------------------------------------------------------
  initial
  begin
    scl_pull = 1'b0; // both lines released: bus idle
    sda_pull = 1'b0;
    bus_err  = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // the target may hold the clock low; wait, bounded
  task automatic rise_scl();
    int w;
    w = 0;
    scl_pull <= 1'b0;
    tick(1);
    while (scl !== 1'b1 && w < 1000)
    begin
      tick(1);
      w++;
    end
    if (w >= 1000)
      bus_err = 1'b1;
  endtask : rise_scl

  // data changes 10 ns after the fall, so setup is 40 ns
  task automatic bit_cell(input logic b, output logic r);
    tick(1);
    sda_pull <= ~b; // released for ack and read bits
    tick(4);
    rise_scl();
    tick(1);
    r = sda;
    tick(1);
    scl_pull <= 1'b1;
  endtask : bit_cell

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_cell(d[i], r); // msb first
    bit_cell(1'b1, r);
    ack = ~r;
  endtask : send_byte

  task automatic recv_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_cell(1'b1, r);
      d[i] = r;
    end
    bit_cell(~ack, r); // last byte left without ack
  endtask : recv_byte

  // long low phase first so the target's ack is gone before scl rises
  task automatic start_cond();
    tick(5);
    sda_pull <= 1'b0;
    tick(1);
    rise_scl();
    tick(4);
    sda_pull <= 1'b1; // data falls while clock high
    tick(4);
    scl_pull <= 1'b1;
  endtask : start_cond

  task automatic stop_cond();
    tick(1);
    sda_pull <= 1'b1;
    tick(4);
    rise_scl();
    tick(4);
    sda_pull <= 1'b0; // data rises while clock high
    tick(4);
  endtask : stop_cond
endmodule : axc_ctl_model

// [verif/testbench.sv]
`timescale 1ns/10ps

module testbench;
  // ----------------------------------------------------------
  // bench: controller model, converter stub, scenarios
  // ----------------------------------------------------------
  localparam int CONV_LEN = 50;
  localparam int ADC_DLY  = 20;

  logic        clk, sys_rst, addr_strap, conv_done, bus_err;
  logic        scl_out, scl_oe, sda_out, sda_oe, reg_wr_stb;
  logic        conv_start, bus_busy, ctl_scl, ctl_sda;
  logic [7:0]  register_pointer, reg_wr_data, control_register_two;
  logic [7:0]  reg_rd_data;
  logic [11:0] x_sample, y_sample, z_sample;
  wire logic   scl, sda;
  int          num_errors = 0, num_checks = 0;
  int          adc_cnt = 0, held = 0, n_conv = 0, n_wr = 0;

  // pull-ups: a line is low while anyone pulls it
  assign scl = ~((scl_oe & ~scl_out) | ctl_scl);
  assign sda = ~((sda_oe & ~sda_out) | ctl_sda);
  // user register stand-in, a distinct value per pointer
  assign reg_rd_data = ~register_pointer;

  axc_i2c_target #(.CONV_CYCLES(CONV_LEN)) axc_i2c_target_i
  (
    .clk(clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda),
    .addr_strap(addr_strap), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_out(sda_out), .sda_oe(sda_oe),
    .register_pointer(register_pointer), .reg_wr_stb(reg_wr_stb),
    .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
    .control_register_two(control_register_two),
    .conv_start(conv_start), .conv_done(conv_done),
    .x_sample(x_sample), .y_sample(y_sample), .z_sample(z_sample),
    .bus_busy(bus_busy)
  );

  axc_ctl_model axc_ctl_model_i
  (
    .clk(clk), .scl(scl), .sda(sda), .scl_pull(ctl_scl),
    .sda_pull(ctl_sda), .bus_err(bus_err)
  );

  // converter answers well inside the hold limit, so hold ends on done
  always @(posedge clk)
  begin
    conv_done <= 1'b0;
    if (adc_cnt == 1)
      conv_done <= 1'b1;
    if (adc_cnt > 0)
      adc_cnt <= adc_cnt - 1;
    if (conv_start === 1'b1)
    begin
      adc_cnt <= ADC_DLY;
      n_conv  <= n_conv + 1;
    end
    if (scl_oe === 1'b1)
      held <= held + 1;
    if (reg_wr_stb === 1'b1)
      n_wr <= n_wr + 1;
  end

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run

  task automatic open_ptr(input logic [7:0] ptr);
    logic a;
    axc_ctl_model_i.start_cond();
    axc_ctl_model_i.send_byte({6'h0C, addr_strap, 1'b0}, a);
    chk_bit(a, 1'b1);
    chk_bit(bus_busy, 1'b1);
    axc_ctl_model_i.send_byte(ptr, a); // msb kept clear
    chk_bit(a, 1'b1);
  endtask : open_ptr

  task automatic read_seq(input int n, input logic [7:0] e [0:5]);
    logic       a;
    logic [7:0] d;
    axc_ctl_model_i.start_cond();
    axc_ctl_model_i.send_byte({6'h0C, addr_strap, 1'b1}, a);
    chk_bit(a, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      axc_ctl_model_i.recv_byte(i < n - 1, d);
      chk_byte(d, e[i]);
    end
    axc_ctl_model_i.stop_cond();
  endtask : read_seq

  task automatic t_reset();
    chk_byte(control_register_two, 8'h00);
    chk_byte(register_pointer, 8'h00);
    chk_bit(bus_busy, 1'b0);
    chk_bit(sda_oe, 1'b0);
    chk_bit(scl_oe, 1'b0);
  endtask : t_reset

  // mode set first after power-up
  task automatic t_write();
    logic a;
    open_ptr(8'h0E);
    axc_ctl_model_i.send_byte(8'h01, a);
    chk_bit(a, 1'b1);
    axc_ctl_model_i.send_byte(8'h5A, a);
    chk_bit(a, 1'b1);
    axc_ctl_model_i.stop_cond();
    axc_ctl_model_i.tick(4);
    chk_byte(control_register_two, 8'h01);
    chk_byte(reg_wr_data, 8'h5A);
    chk_byte(register_pointer, 8'h10);
    chk_bit(n_wr == 2, 1'b1);
    chk_bit(bus_busy, 1'b0);
  endtask : t_write

  task automatic t_addr();
    logic       a;
    logic [6:0] cand [0:2];
    cand = '{7'h18, 7'h19, 7'h1C};
    for (int s = 0; s < 2; s++)
    begin
      addr_strap <= s[0];
      axc_ctl_model_i.tick(8);
      foreach (cand[k])
      begin
        axc_ctl_model_i.start_cond();
        axc_ctl_model_i.send_byte({cand[k], 1'b0}, a);
        chk_bit(a, cand[k] == {6'h0C, s[0]});
        axc_ctl_model_i.send_byte(8'h0E, a);
        chk_bit(a, cand[k] == {6'h0C, s[0]});
        axc_ctl_model_i.stop_cond();
      end
    end
    addr_strap <= 1'b0;
    axc_ctl_model_i.tick(8);
  endtask : t_addr

  // +0.8 g on x, -0.8 g on y, 0 g on z, hold bit set
  task automatic t_hold();
    held   = 0;
    n_conv = 0;
    open_ptr(8'h00);
    read_seq(6, '{8'hB3, 8'h30, 8'h4C, 8'hD0, 8'h80, 8'h00});
    chk_bit(n_conv == 1, 1'b1);
    chk_bit(held > 0, 1'b1);
    chk_bit(held < ADC_DLY, 1'b1);
  endtask : t_hold

  task automatic t_user();
    open_ptr(8'h20);
    read_seq(2, '{8'hDF, 8'hDE, 8'h00, 8'h00, 8'h00, 8'h00});
    chk_byte(register_pointer, 8'h21);
  endtask : t_user

  task automatic t_nohold();
    logic a;
    open_ptr(8'h0E);
    axc_ctl_model_i.send_byte(8'h00, a);
    axc_ctl_model_i.stop_cond();
    x_sample <= 12'h4CD;
    y_sample <= 12'h800;
    held = 0;
    open_ptr(8'h00);
    read_seq(3, '{8'h4C, 8'hD0, 8'h80, 8'h00, 8'h00, 8'h00});
    chk_bit(held == 0, 1'b1);
  endtask : t_nohold

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    #500000;
    num_errors++;
    complete_run();
  end

  initial
  begin
    sys_rst    = 1'b1;
    addr_strap = 1'b0;
    conv_done  = 1'b0;
    x_sample   = 12'hB33;
    y_sample   = 12'h4CD;
    z_sample   = 12'h800;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge clk);
    t_reset();
    t_write();
    t_addr();
    t_hold();
    t_user();
    t_nohold();
    chk_bit(bus_err, 1'b0);
    complete_run();
  end
endmodule : testbench
